/* File: logic/dps_sequencer.sv */
// top of the dispense pulse sequencer: trigger intake, phase sequencing, query
// assumes all inputs synchronous to clk_i; key and serial triggers are one-cycle pulses
//
// Behaviour
// - key, serial or controller trigger each start one of four setups
// - burst: one trigger runs the programmed count of open/close cycles back to back
// - single-shot: count one, each dot needs its own trigger from the controller
// - count zero: keep cycling while controller trigger high, stop new cycles when low
// - infinite uses stored durations; back key stops key-started infinite dispensing
// - external: valve open while trigger high, closing starts when it drops
// - open zero, close zero, count one means external mode
// - external mode ignores triggers until the valve has fully closed
// - external mode only on the first setup, others internally timed
// - open phase programmable in 0.1 ms steps up to 5000 ms
// - close phase programmable in 0.1 ms steps up to 5000 ms
// - open and close 0.7 to 5000 ms, or both zero for external
// - pulse count 1 to 500000, zero means infinite
// - sequence: trigger delay, start setup, sequence delay, end setup; delays 0.7 ms-5 s or 0
// - a sequence whose end setup equals its start setup is refused
// - sequence mode on and defined: whole sequence runs; otherwise just the setup
// - one sequence per setup, settable and readable mode flag, per-setup query
// - edits are saved only on confirm, cancel discards, both leave edit
`timescale 1ns/1ps
`default_nettype none
module dps_sequencer
	import dps_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic key_trigger_i,
	input wire logic [1:0] panel_setup_i,
	input wire logic back_key_i,
	input wire logic serial_trigger_i,
	input wire logic [1:0] serial_setup_i,
	input wire logic plc_trigger_i,
	input wire logic [1:0] plc_setup_i,
	input wire logic edit_load_i,
	input wire logic [1:0] edit_setup_i,
	input wire logic [DUR_W-1:0] edit_open_i,
	input wire logic [DUR_W-1:0] edit_close_i,
	input wire logic [CNT_W-1:0] edit_count_i,
	input wire logic edit_confirm_i,
	input wire logic edit_cancel_i,
	input wire logic seq_define_i,
	input wire logic [DUR_W-1:0] seq_trig_dly_i,
	input wire logic [1:0] seq_start_i,
	input wire logic [DUR_W-1:0] seq_dly_i,
	input wire logic [1:0] seq_end_i,
	input wire logic mode_write_i,
	input wire logic mode_value_i,
	input wire logic [1:0] query_setup_i,
	output logic valve_open_o,
	output logic dispense_done_ok_o,
	output logic [1:0] active_setup_o,
	output logic edit_active_o,
	output logic cfg_ack_o,
	output logic cfg_nak_o,
	output logic seq_mode_o,
	output logic query_valid_o,
	output logic [DUR_W-1:0] query_trig_dly_o,
	output logic [DUR_W-1:0] query_seq_dly_o,
	output logic [1:0] query_end_o,
	output logic [DUR_W-1:0] query_open_o,
	output logic [DUR_W-1:0] query_close_o,
	output logic [CNT_W-1:0] query_count_o
);
	// ************************************************************
	// declarations
	// ************************************************************
	dps_cfg_if cfg ();

	dps_state_t state_r;
	dps_state_t state_nxt;
	logic [1:0] setup_r;
	logic [1:0] setup_nxt;
	logic chain_r;
	logic chain_nxt;
	logic part2_r;
	logic part2_nxt;
	logic [CNT_W-1:0] remain_r;
	logic [CNT_W-1:0] remain_nxt;
	logic infinite_r;
	logic infinite_nxt;
	logic src_plc_r;
	logic stop_r;
	logic plc_prev_r;
	logic tmr_load;
	logic [DUR_W-1:0] tmr_steps;
	logic tmr_done;
	logic trig_any;
	logic [1:0] trig_setup;
	logic trig_plc;
	logic launch;
	logic [1:0] launch_s;
	logic finish;
	logic stop_now;
	logic [NSETUP-1:0] ext_vec;

	// ************************************************************
	// submodules
	// ************************************************************
	dps_setup_store u_store (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.cfg(cfg.store),
		.edit_load_i(edit_load_i),
		.edit_setup_i(edit_setup_i),
		.edit_open_i(edit_open_i),
		.edit_close_i(edit_close_i),
		.edit_count_i(edit_count_i),
		.edit_confirm_i(edit_confirm_i),
		.edit_cancel_i(edit_cancel_i),
		.seq_define_i(seq_define_i),
		.seq_trig_dly_i(seq_trig_dly_i),
		.seq_start_i(seq_start_i),
		.seq_dly_i(seq_dly_i),
		.seq_end_i(seq_end_i),
		.mode_write_i(mode_write_i),
		.mode_value_i(mode_value_i),
		.edit_active_o(edit_active_o),
		.cfg_ack_o(cfg_ack_o),
		.cfg_nak_o(cfg_nak_o)
	);

	dps_phase_timer u_timer (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.load_i(tmr_load),
		.steps_i(tmr_steps),
		.done_o(tmr_done)
	);

	// ************************************************************
	// mode decode per setup
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NSETUP; gi++) begin : g_ext
			// only the first setup may be externally timed
			assign ext_vec[gi] = (gi == 0) && (cfg.open_d[gi] == DUR_ZERO)
				&& (cfg.close_d[gi] == DUR_ZERO) && (cfg.count[gi] == CNT_ONE);
		end
	endgenerate

	// ************************************************************
	// trigger intake
	// ************************************************************
	// the controller line is a level; only its rising edge starts a run
	assign trig_plc = plc_trigger_i && !plc_prev_r;
	assign trig_any = key_trigger_i || serial_trigger_i || trig_plc;

	// fixed priority when sources coincide: key, then serial, then controller
	always_comb begin
		if (key_trigger_i) begin
			trig_setup = panel_setup_i;
		end else if (serial_trigger_i) begin
			trig_setup = serial_setup_i;
		end else begin
			trig_setup = plc_setup_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			plc_prev_r <= 1'b0;
		end else begin
			plc_prev_r <= plc_trigger_i;
		end
	end

	// infinite stop: back key is latched, a dropped controller line counts only if still low when a close phase ends
	assign stop_now = stop_r || back_key_i || (src_plc_r && !plc_trigger_i);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			src_plc_r <= 1'b0;
			stop_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			stop_r <= 1'b0;
			if (trig_any) begin
				src_plc_r <= !key_trigger_i && !serial_trigger_i;
			end
		end else if (back_key_i) begin
			stop_r <= 1'b1;
		end
	end

	// ************************************************************
	// phase sequencing
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		setup_nxt = setup_r;
		chain_nxt = chain_r;
		part2_nxt = part2_r;
		remain_nxt = remain_r;
		infinite_nxt = infinite_r;
		tmr_load = 1'b0;
		tmr_steps = DUR_ONE;
		launch = 1'b0;
		launch_s = setup_r;
		finish = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				// triggers are only taken here, so a run in progress ignores them
				if (trig_any) begin
					setup_nxt = trig_setup;
					chain_nxt = cfg.seq_mode && cfg.seq_valid[trig_setup];
					part2_nxt = 1'b0;
					if (cfg.seq_mode && cfg.seq_valid[trig_setup]
						&& (cfg.trig_dly[trig_setup] != DUR_ZERO)) begin
						state_nxt = ST_TDLY;
						tmr_load = 1'b1;
						tmr_steps = cfg.trig_dly[trig_setup];
					end else begin
						launch = 1'b1;
						launch_s = trig_setup;
					end
				end
			end
			ST_TDLY: begin
				if (tmr_done) begin
					launch = 1'b1;
					launch_s = setup_r;
				end
			end
			ST_OPEN: begin
				if (tmr_done) begin
					state_nxt = ST_CLOSE;
					tmr_load = 1'b1;
					tmr_steps = cfg.close_d[setup_r];
				end
			end
			ST_CLOSE: begin
				if (tmr_done) begin
					if (infinite_r ? !stop_now : (remain_r > CNT_ONE)) begin
						// next cycle starts with no gap and no new trigger
						state_nxt = ST_OPEN;
						remain_nxt = infinite_r ? remain_r : remain_r - CNT_ONE;
						tmr_load = 1'b1;
						tmr_steps = cfg.open_d[setup_r];
					end else begin
						finish = 1'b1;
					end
				end
			end
			ST_EXT_OPEN: begin
				// open phase lasts exactly as long as the controller line stays high
				if (!plc_trigger_i) begin
					state_nxt = ST_EXT_CLOSE;
					tmr_load = 1'b1;
					tmr_steps = EXT_CLOSE_STEPS;
				end
			end
			ST_EXT_CLOSE: begin
				if (tmr_done) begin
					finish = 1'b1;
				end
			end
			ST_SDLY: begin
				if (tmr_done) begin
					launch = 1'b1;
					launch_s = cfg.seq_end[setup_r];
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (finish) begin
			if (chain_r && !part2_r) begin
				part2_nxt = 1'b1;
				if (cfg.seq_dly[setup_r] != DUR_ZERO) begin
					state_nxt = ST_SDLY;
					tmr_load = 1'b1;
					tmr_steps = cfg.seq_dly[setup_r];
				end else begin
					launch = 1'b1;
					launch_s = cfg.seq_end[setup_r];
				end
			end else begin
				state_nxt = ST_IDLE;
			end
		end
		if (launch) begin
			setup_nxt = launch_s;
			remain_nxt = cfg.count[launch_s];
			infinite_nxt = (cfg.count[launch_s] == CNT_ZERO);
			if (ext_vec[launch_s]) begin
				state_nxt = ST_EXT_OPEN;
			end else begin
				state_nxt = ST_OPEN;
				tmr_load = 1'b1;
				tmr_steps = cfg.open_d[launch_s];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= ST_IDLE;
			setup_r <= SETUP_FIRST;
			chain_r <= 1'b0;
			part2_r <= 1'b0;
			remain_r <= CNT_ZERO;
			infinite_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			setup_r <= setup_nxt;
			chain_r <= chain_nxt;
			part2_r <= part2_nxt;
			remain_r <= remain_nxt;
			infinite_r <= infinite_nxt;
		end
	end

	// ************************************************************
	// valve and status outputs
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			valve_open_o <= 1'b0;
			dispense_done_ok_o <= 1'b1;
			active_setup_o <= SETUP_FIRST;
		end else begin
			valve_open_o <= (state_nxt == ST_OPEN) || (state_nxt == ST_EXT_OPEN);
			dispense_done_ok_o <= (state_nxt == ST_IDLE);
			active_setup_o <= setup_nxt;
		end
	end

	// ************************************************************
	// query of stored parameters
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			seq_mode_o <= 1'b0;
			query_valid_o <= 1'b0;
			query_trig_dly_o <= DUR_ZERO;
			query_seq_dly_o <= DUR_ZERO;
			query_end_o <= SETUP_FIRST;
			query_open_o <= DUR_ZERO;
			query_close_o <= DUR_ZERO;
			query_count_o <= CNT_ZERO;
		end else begin
			seq_mode_o <= cfg.seq_mode;
			query_valid_o <= cfg.seq_valid[query_setup_i];
			query_trig_dly_o <= cfg.trig_dly[query_setup_i];
			query_seq_dly_o <= cfg.seq_dly[query_setup_i];
			query_end_o <= cfg.seq_end[query_setup_i];
			query_open_o <= cfg.open_d[query_setup_i];
			query_close_o <= cfg.close_d[query_setup_i];
			query_count_o <= cfg.count[query_setup_i];
		end
	end
endmodule : dps_sequencer
`default_nettype wire

/* File: logic/dps_pkg.sv */
// constants, field widths and state codes for the dispense pulse sequencer
// assumes a single 25 MHz clock shared by every module of the block
package dps_pkg;
	// ************************************************************
	// clock and time base
	// ************************************************************
	localparam int CLK_NS = 40;
	// one duration step is 0.1 ms
	localparam int STEP_NS = 100000;
	localparam int TICK_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRE_W = 12;
	localparam logic [PRE_W-1:0] TICK_RELOAD = PRE_W'(TICK_CYC - 1);
	// ************************************************************
	// parameter fields, durations in 0.1 ms steps
	// ************************************************************
	localparam int DUR_W = 16;
	localparam int CNT_W = 19;
	localparam int NSETUP = 4;
	localparam logic [DUR_W-1:0] DUR_ZERO = 16'h0000;
	localparam logic [DUR_W-1:0] DUR_ONE = 16'h0001;
	// 0.7 ms and 5000 ms
	localparam logic [DUR_W-1:0] DUR_MIN = 16'h0007;
	localparam logic [DUR_W-1:0] DUR_MAX = 16'hC350;
	// delays: 0.7 ms to 5 s
	localparam logic [DUR_W-1:0] DLY_MIN = 16'h0007;
	localparam logic [DUR_W-1:0] DLY_MAX = 16'hC350;
	// valve closing time used after an externally timed open phase
	localparam logic [DUR_W-1:0] EXT_CLOSE_STEPS = 16'h0007;
	localparam logic [CNT_W-1:0] CNT_ZERO = 19'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;
	localparam logic [CNT_W-1:0] CNT_MAX = 19'h7A120;
	// ************************************************************
	// power-up setup values
	// ************************************************************
	localparam logic [NSETUP-1:0][DUR_W-1:0] OPEN_RST = {16'h0050, 16'h003C, 16'h0028, 16'h0014};
	localparam logic [DUR_W-1:0] CLOSE_RST = 16'h0032;
	localparam logic [CNT_W-1:0] COUNT_RST = 19'h0000A;
	localparam logic [1:0] SETUP_FIRST = 2'h0;
	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TDLY = 3'b001,
		ST_OPEN = 3'b010,
		ST_CLOSE = 3'b011,
		ST_EXT_OPEN = 3'b100,
		ST_EXT_CLOSE = 3'b101,
		ST_SDLY = 3'b110
	} dps_state_t;
endpackage : dps_pkg

/* File: logic/dps_cfg_if.sv */
// stored setups, sequences and sequence-mode flag handed to the sequencer
// assumes one writer (the setup store) and readers on the same clock
`timescale 1ns/1ps
`default_nettype none
interface dps_cfg_if;
	import dps_pkg::*;
	logic [NSETUP-1:0][DUR_W-1:0] open_d;
	logic [NSETUP-1:0][DUR_W-1:0] close_d;
	logic [NSETUP-1:0][CNT_W-1:0] count;
	logic [NSETUP-1:0] seq_valid;
	logic [NSETUP-1:0][DUR_W-1:0] trig_dly;
	logic [NSETUP-1:0][DUR_W-1:0] seq_dly;
	logic [NSETUP-1:0][1:0] seq_end;
	logic seq_mode;
	modport store (output open_d, close_d, count, seq_valid, trig_dly, seq_dly, seq_end, seq_mode);
	modport user (input open_d, close_d, count, seq_valid, trig_dly, seq_dly, seq_end, seq_mode);
endinterface : dps_cfg_if
`default_nettype wire

/* File: logic/dps_phase_timer.sv */
// phase timer counting in 0.1 ms steps
// assumes load_i is never given a zero step count
`timescale 1ns/1ps
`default_nettype none
module dps_phase_timer
	import dps_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic load_i,
	input wire logic [DUR_W-1:0] steps_i,
	output logic done_o
);
	logic run_r;
	logic [DUR_W-1:0] cnt_r;
	logic [PRE_W-1:0] pre_r;

	// a reload wins over a running count so back-to-back phases never slip
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			run_r <= 1'b0;
			cnt_r <= DUR_ZERO;
			pre_r <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				run_r <= 1'b1;
				cnt_r <= steps_i;
				pre_r <= TICK_RELOAD;
			end else if (run_r) begin
				if (pre_r == '0) begin
					pre_r <= TICK_RELOAD;
					if (cnt_r == DUR_ONE) begin
						run_r <= 1'b0;
						done_o <= 1'b1;
					end else begin
						cnt_r <= cnt_r - DUR_ONE;
					end
				end else begin
					pre_r <= pre_r - 1'b1;
				end
			end
		end
	end
endmodule : dps_phase_timer
`default_nettype wire

/* File: logic/dps_setup_store.sv */
// setup and sequence storage with edit, confirm and range checks
// assumes the host changes settings only while the sequencer is idle
`timescale 1ns/1ps
`default_nettype none
module dps_setup_store
	import dps_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	dps_cfg_if.store cfg,
	input wire logic edit_load_i,
	input wire logic [1:0] edit_setup_i,
	input wire logic [DUR_W-1:0] edit_open_i,
	input wire logic [DUR_W-1:0] edit_close_i,
	input wire logic [CNT_W-1:0] edit_count_i,
	input wire logic edit_confirm_i,
	input wire logic edit_cancel_i,
	input wire logic seq_define_i,
	input wire logic [DUR_W-1:0] seq_trig_dly_i,
	input wire logic [1:0] seq_start_i,
	input wire logic [DUR_W-1:0] seq_dly_i,
	input wire logic [1:0] seq_end_i,
	input wire logic mode_write_i,
	input wire logic mode_value_i,
	output logic edit_active_o,
	output logic cfg_ack_o,
	output logic cfg_nak_o
);
	logic [1:0] st_setup_r;
	logic [DUR_W-1:0] st_open_r;
	logic [DUR_W-1:0] st_close_r;
	logic [CNT_W-1:0] st_count_r;
	logic ext_ok;
	logic edit_ok;
	logic seq_ok;

	// zero open and close with one pulse is only legal on the first setup
	assign ext_ok = (st_setup_r == SETUP_FIRST) && (st_open_r == DUR_ZERO)
		&& (st_close_r == DUR_ZERO) && (st_count_r == CNT_ONE);
	assign edit_ok = ext_ok || ((st_open_r >= DUR_MIN) && (st_open_r <= DUR_MAX)
		&& (st_close_r >= DUR_MIN) && (st_close_r <= DUR_MAX)
		&& (st_count_r <= CNT_MAX));
	assign seq_ok = (seq_start_i != seq_end_i)
		&& ((seq_trig_dly_i == DUR_ZERO) || ((seq_trig_dly_i >= DLY_MIN) && (seq_trig_dly_i <= DLY_MAX)))
		&& ((seq_dly_i == DUR_ZERO) || ((seq_dly_i >= DLY_MIN) && (seq_dly_i <= DLY_MAX)));

	// ************************************************************
	// edit staging: nothing reaches the setup until confirmed
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			edit_active_o <= 1'b0;
			st_setup_r <= SETUP_FIRST;
			st_open_r <= DUR_ZERO;
			st_close_r <= DUR_ZERO;
			st_count_r <= CNT_ZERO;
		end else if (edit_load_i) begin
			edit_active_o <= 1'b1;
			st_setup_r <= edit_setup_i;
			st_open_r <= edit_open_i;
			st_close_r <= edit_close_i;
			st_count_r <= edit_count_i;
		end else if (edit_confirm_i || edit_cancel_i) begin
			edit_active_o <= 1'b0;
		end
	end

	// ************************************************************
	// stored setups and sequences
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg.open_d <= OPEN_RST;
			cfg.close_d <= {NSETUP{CLOSE_RST}};
			cfg.count <= {NSETUP{COUNT_RST}};
			cfg.seq_valid <= '0;
			cfg.trig_dly <= '0;
			cfg.seq_dly <= '0;
			cfg.seq_end <= '0;
			cfg.seq_mode <= 1'b0;
			cfg_ack_o <= 1'b0;
			cfg_nak_o <= 1'b0;
		end else begin
			cfg_ack_o <= 1'b0;
			cfg_nak_o <= 1'b0;
			if (edit_active_o && edit_confirm_i && !edit_load_i) begin
				cfg_ack_o <= edit_ok;
				cfg_nak_o <= !edit_ok;
				if (edit_ok) begin
					cfg.open_d[st_setup_r] <= st_open_r;
					cfg.close_d[st_setup_r] <= st_close_r;
					cfg.count[st_setup_r] <= st_count_r;
				end
			end else if (seq_define_i) begin
				cfg_ack_o <= seq_ok;
				cfg_nak_o <= !seq_ok;
				if (seq_ok) begin
					// one slot per start setup, a new definition replaces the old
					cfg.seq_valid[seq_start_i] <= 1'b1;
					cfg.trig_dly[seq_start_i] <= seq_trig_dly_i;
					cfg.seq_dly[seq_start_i] <= seq_dly_i;
					cfg.seq_end[seq_start_i] <= seq_end_i;
				end
			end else if (mode_write_i) begin
				cfg_ack_o <= 1'b1;
				cfg.seq_mode <= mode_value_i;
			end
		end
	end
endmodule : dps_setup_store
`default_nettype wire

/* File: verification/dps_monitor.sv */
// checker of the sequencer port timing
// assumes binding onto dps_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dps_monitor (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic key_trigger_i,
	input wire logic edit_load_i,
	input wire logic edit_confirm_i,
	input wire logic edit_cancel_i,
	input wire logic seq_define_i,
	input wire logic [1:0] seq_start_i,
	input wire logic [1:0] seq_end_i,
	input wire logic mode_write_i,
	input wire logic valve_open_o,
	input wire logic dispense_done_ok_o,
	input wire logic [1:0] active_setup_o,
	input wire logic edit_active_o,
	input wire logic cfg_ack_o,
	input wire logic cfg_nak_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// ******
	// open phase length
	// ******
	// counter, since an open phase is far beyond any repetition count
	logic [26:0] open_cnt_r;
	always_ff @(posedge clk_i) begin
		if (srst_i || !valve_open_o) begin
			open_cnt_r <= 27'h0000000;
		end else begin
			open_cnt_r <= open_cnt_r + 27'h0000001;
		end
	end
	sequence s_run_begins;
		!dispense_done_ok_o ##1 !dispense_done_ok_o;
	endsequence
	sequence s_refused;
		cfg_nak_o && !cfg_ack_o;
	endsequence
	// ******
	// properties
	// ******
	a_trigger_starts_run: assert property (dispense_done_ok_o && key_trigger_i |=> s_run_begins)
		else $error("idle key trigger did not start a run");
	a_valve_busy_only: assert property (valve_open_o |-> !dispense_done_ok_o)
		else $error("valve open while idle");
	a_open_min_len: assert property ($fell(valve_open_o) && active_setup_o != 2'h0 |-> open_cnt_r >= 27'h000445C)
		else $error("internal open phase shorter than 0.7 ms");
	a_ack_nak_apart: assert property (cfg_ack_o |-> !cfg_nak_o)
		else $error("accept and refuse together");
	a_ack_one_cycle: assert property (cfg_ack_o |=> !cfg_ack_o)
		else $error("accept pulse longer than one cycle");
	a_edit_staged: assert property (edit_load_i && !edit_confirm_i && !edit_cancel_i |=> edit_active_o)
		else $error("loaded edit not pending");
	a_cancel_drops: assert property (edit_cancel_i && !edit_load_i |=> !edit_active_o)
		else $error("cancel left edit pending");
	a_mode_acked: assert property (mode_write_i && !edit_confirm_i && !seq_define_i |=> cfg_ack_o)
		else $error("mode write not accepted");
	a_same_setup_refused: assert property (seq_define_i && !edit_confirm_i && seq_start_i == seq_end_i |=> s_refused)
		else $error("sequence with equal ends accepted");
endmodule : dps_monitor
bind dps_sequencer dps_monitor u_mon (
	.clk_i,
	.srst_i,
	.key_trigger_i,
	.edit_load_i,
	.edit_confirm_i,
	.edit_cancel_i,
	.seq_define_i,
	.seq_start_i,
	.seq_end_i,
	.mode_write_i,
	.valve_open_o,
	.dispense_done_ok_o,
	.active_setup_o,
	.edit_active_o,
	.cfg_ack_o,
	.cfg_nak_o
);
`default_nettype wire

/* File: verification/dps_plc_model.sv */
// machine controller model driving the discrete trigger and setup lines
// assumes go_i is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none
module dps_plc_model (
	input wire logic clk_i,
	input wire logic done_i,
	input wire logic go_i,
	input wire logic [1:0] setup_i,
	input wire logic [15:0] hold_i,
	output logic trig_o,
	output logic [1:0] setup_o
);
	int left_r;
	initial begin
		trig_o = 1'h0;
		setup_o = 2'h0;
		left_r = 0;
	end
	// select changes with the trigger so both are seen at the same edge
	always @(posedge clk_i) begin
		if (go_i && done_i && !trig_o) begin
			setup_o <= setup_i;
			trig_o <= 1'h1;
			left_r <= hold_i;
		end else if (trig_o) begin
			left_r <= left_r - 1;
			trig_o <= (left_r > 1);
		end
	end
endmodule : dps_plc_model
`default_nettype wire

/* File: verification/dps_sequencer_test.sv */
// self-checking bench for the dispense pulse sequencer
// assumes the controller model drives the discrete trigger lines
`timescale 1ns/1ps
`default_nettype none
module dps_sequencer_test
	import dps_pkg::*;
();
	logic clk_i, srst_i, key_trigger_i, back_key_i, serial_trigger_i, plc_trigger_i;
	logic edit_load_i, edit_confirm_i, edit_cancel_i, seq_define_i, mode_write_i, mode_value_i;
	logic [1:0] panel_setup_i, serial_setup_i, plc_setup_i, edit_setup_i, seq_start_i, seq_end_i;
	logic [1:0] query_setup_i, active_setup_o, query_end_o, plc_sel, r;
	logic [DUR_W-1:0] edit_open_i, edit_close_i, seq_trig_dly_i, seq_dly_i, query_open_o;
	logic [DUR_W-1:0] query_trig_dly_o, query_seq_dly_o, query_close_o;
	logic [CNT_W-1:0] edit_count_i, query_count_o;
	logic valve_open_o, dispense_done_ok_o, edit_active_o, cfg_ack_o, cfg_nak_o;
	logic seq_mode_o, query_valid_o, plc_go;
	logic [15:0] plc_hold;
	int failures, checks, rises, highs;
	dps_sequencer DUT (
		.clk_i, .srst_i, .key_trigger_i, .panel_setup_i, .back_key_i, .serial_trigger_i,
		.serial_setup_i, .plc_trigger_i, .plc_setup_i, .edit_load_i, .edit_setup_i,
		.edit_open_i, .edit_close_i, .edit_count_i, .edit_confirm_i, .edit_cancel_i,
		.seq_define_i, .seq_trig_dly_i, .seq_start_i, .seq_dly_i, .seq_end_i, .mode_write_i,
		.mode_value_i, .query_setup_i, .valve_open_o, .dispense_done_ok_o, .active_setup_o,
		.edit_active_o, .cfg_ack_o, .cfg_nak_o, .seq_mode_o, .query_valid_o, .query_trig_dly_o,
		.query_seq_dly_o, .query_end_o, .query_open_o, .query_close_o, .query_count_o
	);
	dps_plc_model u_plc (
		.clk_i,
		.done_i(dispense_done_ok_o),
		.go_i(plc_go),
		.setup_i(plc_sel),
		.hold_i(plc_hold),
		.trig_o(plc_trigger_i),
		.setup_o(plc_setup_i)
	);
	// ******
	// shared tasks
	// ******
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// answer may come one or two cycles after the request edge
	task automatic answer();
		r = 2'h0;
		repeat (2) begin
			@(negedge clk_i);
			{edit_load_i, edit_confirm_i, edit_cancel_i, seq_define_i, mode_write_i} = 5'h00;
			r = r | {cfg_ack_o, cfg_nak_o};
		end
	endtask : answer
	task automatic query(input logic [1:0] s);
		query_setup_i = s;
		repeat (2) @(negedge clk_i);
	endtask : query
	task automatic edit(input logic [1:0] s, input logic [15:0] o, c, input logic [18:0] n,
		input logic conf);
		@(negedge clk_i);
		edit_load_i = 1'h1;
		edit_setup_i = s;
		edit_open_i = o;
		edit_close_i = c;
		edit_count_i = n;
		@(negedge clk_i);
		edit_load_i = 1'h0;
		chk(edit_active_o, 1'h1);
		edit_confirm_i = conf;
		edit_cancel_i = !conf;
		answer();
		chk(edit_active_o, 1'h0);
	endtask : edit
	task automatic seq(input logic [15:0] d, input logic [1:0] st, en);
		seq_trig_dly_i = d;
		seq_start_i = st;
		seq_end_i = en;
		seq_define_i = 1'h1;
		answer();
	endtask : seq
	task automatic run();
		logic prev;
		int n;
		prev = 1'h0;
		n = 0;
		rises = 0;
		highs = 0;
		while (dispense_done_ok_o !== 1'h1 && n < 90000) begin
			rises += int'(valve_open_o === 1'h1 && prev !== 1'h1);
			highs += int'(valve_open_o === 1'h1);
			prev = valve_open_o;
			n++;
			@(negedge clk_i);
		end
		chk(n < 90000, 1'h1);
	endtask : run
	// ******
	// scenarios
	// ******
	task automatic t_config();
		for (int i = 0; i < 4; i++) begin
			query(2'(i));
			chk(query_open_o, 32'h14 * (i + 1));
			chk(query_close_o, 16'h32);
			chk({query_count_o, query_valid_o}, {19'hA, 1'h0});
		end
		edit(2'h1, 16'h6, 16'h7, 19'h2, 1'h1);
		chk(r, 2'h1);
		edit(2'h1, 16'h7, 16'hC351, 19'h2, 1'h1);
		chk(r, 2'h1);
		edit(2'h1, 16'h7, 16'h7, 19'h7A121, 1'h1);
		chk(r, 2'h1);
		edit(2'h2, 16'h0, 16'h0, 19'h1, 1'h1);
		chk(r, 2'h1);
		edit(2'h1, 16'h8, 16'h8, 19'h3, 1'h0);
		query(2'h1);
		chk({r, query_open_o}, {2'h0, 16'h28});
		edit(2'h0, 16'h0, 16'h0, 19'h1, 1'h1);
		chk(r, 2'h2);
		edit(2'h1, 16'h7, 16'h7, 19'h2, 1'h1);
		query(2'h1);
		chk({r, query_open_o}, {2'h2, 16'h7});
		chk(query_count_o, 19'h2);
		seq(16'h0, 2'h1, 2'h1);
		chk(r, 2'h1);
		seq(16'h6, 2'h1, 2'h0);
		chk(r, 2'h1);
		seq(16'hC350, 2'h2, 2'h3);
		query(2'h2);
		chk({r, query_valid_o, query_end_o, query_trig_dly_o}, {2'h2, 3'h7, 16'hC350});
		chk(query_seq_dly_o, 16'h0);
		mode_value_i = 1'h1;
		mode_write_i = 1'h1;
		answer();
		chk({r, seq_mode_o}, 3'h5);
		mode_value_i = 1'h0;
		mode_write_i = 1'h1;
		answer();
		chk({r, seq_mode_o}, 3'h4);
	endtask : t_config
	task automatic t_burst();
		seq(16'h0, 2'h1, 2'h0);
		mode_value_i = 1'h1;
		mode_write_i = 1'h1;
		answer();
		serial_setup_i = 2'h1;
		serial_trigger_i = 1'h1;
		@(negedge clk_i);
		serial_trigger_i = 1'h0;
		panel_setup_i = 2'h2;
		key_trigger_i = 1'h1;
		chk({dispense_done_ok_o, active_setup_o}, 3'h1);
		@(negedge clk_i);
		key_trigger_i = 1'h0;
		run();
		chk(rises, 3);
		chk(highs >= 35001 && highs <= 35003, 1'h1);
		chk(active_setup_o, 2'h0);
	endtask : t_burst
	task automatic t_external();
		plc_sel = 2'h0;
		plc_hold = 16'h00C8;
		plc_go = 1'h1;
		@(negedge clk_i);
		plc_go = 1'h0;
		repeat (100) @(negedge clk_i);
		chk(valve_open_o, 1'h1);
		panel_setup_i = 2'h1;
		key_trigger_i = 1'h1;
		@(negedge clk_i);
		key_trigger_i = 1'h0;
		run();
		chk(rises, 1);
		chk(highs >= 97 && highs <= 101, 1'h1);
		chk(active_setup_o, 2'h0);
	endtask : t_external
	// ******
	// main sequence
	// ******
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		{key_trigger_i, back_key_i, serial_trigger_i, edit_load_i, edit_confirm_i} = 5'h00;
		{edit_cancel_i, seq_define_i, mode_write_i, mode_value_i, plc_go} = 5'h00;
		{panel_setup_i, serial_setup_i, edit_setup_i, query_setup_i, plc_sel} = 10'h000;
		{edit_open_i, edit_close_i, seq_trig_dly_i, seq_dly_i, plc_hold} = 80'h0;
		{seq_start_i, seq_end_i, edit_count_i} = 23'h0;
		srst_i = 1'h1;
		repeat (5) @(negedge clk_i);
		srst_i = 1'h0;
		t_config();
		t_burst();
		t_external();
		end_sim();
	end
	// the runs take near 106000 cycles; the limit leaves margin
	initial begin
		#5000000;
		failures++;
		end_sim();
	end
endmodule : dps_sequencer_test
`default_nettype wire
